// [src/pie_cfg.svh]
// offsets, field positions, reset values and timing counts of the event interrupt mask block
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH

// register indices; byte address is four times the index
`define PIE_IDX_CTRL 8'h00
`define PIE_IDX_MASK 8'h12
`define PIE_IDX_STATUS 8'h13
`define PIE_ADDR_W 8

// event bit positions, shared by mask and latched status
`define PIE_B_ANEG_ERR 15
`define PIE_B_SPEED 14
`define PIE_B_DUPLEX 13
`define PIE_B_PAGE 12
`define PIE_B_LINK_FAIL 11
`define PIE_B_LINK_OK 10
`define PIE_B_XOVER 6
`define PIE_B_DOWNGRADE 5
`define PIE_B_POLARITY 1
`define PIE_B_JABBER 0

// control register: software reset, self clearing
`define PIE_B_SOFT_RESET 15

// kinds of the level-change detectors
`define PIE_KIND_RISE 2'h0
`define PIE_KIND_FALL 2'h1
`define PIE_KIND_TOGGLE 2'h2

// field groups and reset values
`define PIE_EVENT_BITS 16'hFC63
`define PIE_RSVD_BITS 16'h039C
`define PIE_SOFT_KEEP 16'hFEFF
`define PIE_MASK_RESET 16'h0000
`define PIE_STATUS_RESET 16'h0000

// bus answer: cycles from a request to waitrequest low
`define PIE_BUS_LATENCY 1

`endif

// [src/pie_pkg.sv]
// types of the event interrupt mask block
package pie_pkg;
   typedef logic [15:0] pie_word_t;
   typedef enum logic [0:0] {
      PIE_BUS_IDLE,
      PIE_BUS_ANSWER
   } pie_bus_e;
endpackage

// [src/pie_event_irq.sv]
// event interrupt mask register, latched event status and interrupt output
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "pie_cfg.svh"

// Notes on behaviour
// RL1: a 16-bit event interrupt mask register lives at index 0x12.
// RL2: a one in an enable bit lets its latched event raise the interrupt; bits read/write.
// RL3: a zero blocks the event; hardware reset clears all, software reset keeps enables.
// RL4: bit 15 enables the auto-negotiation error event.
// RL5: bit 14 speed change, bit 13 duplex change, bit 12 page received.
// RL6: bit 11 link going down, bit 10 link coming up.
// RL7: bit 6 crossover change, bit 5 wirespeed downgrade from 100 to 10.
// RL8: bit 1 receive polarity change, bit 0 jabber.
// RL9: reserved bits are plain storage; software reset clears bit 8 only; no interrupt effect.
// RL10: negotiation error on master/slave, parallel detect, no common ability, or link timeout.
// RL11: interrupt high while any latched event and its enable are both one.
module pie_event_irq
   import pie_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [`PIE_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_speed_100,
   input wire logic i_full_duplex,
   input wire logic i_page_rx,
   input wire logic i_link_up,
   input wire logic i_mdix,
   input wire logic i_downgrade,
   input wire logic i_polarity_rev,
   input wire logic i_jabber,
   input wire logic i_ms_fault,
   input wire logic i_pd_fault,
   input wire logic i_no_common_hcd,
   input wire logic i_link_timeout,
   output logic o_soft_reset,
   output logic o_irq
);

   // byte addresses of the registers
   localparam logic [`PIE_ADDR_W-1:0] ADDR_CTRL =
      `PIE_ADDR_W'(`PIE_IDX_CTRL << 2);
   localparam logic [`PIE_ADDR_W-1:0] ADDR_MASK =
      `PIE_ADDR_W'(`PIE_IDX_MASK << 2);
   localparam logic [`PIE_ADDR_W-1:0] ADDR_STATUS =
      `PIE_ADDR_W'(`PIE_IDX_STATUS << 2);

   // bus slave state
   pie_bus_e bus_r;
   pie_bus_e bus_nxt;
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // register state
   pie_word_t mask_r;
   pie_word_t mask_nxt;
   pie_word_t status_r;
   pie_word_t status_nxt;
   logic swrst_r;
   logic swrst_nxt;
   logic irq_r;
   logic irq_nxt;

   // event detection state
   logic primed_r;
   logic primed_nxt;
   logic [8:0] now_lv;
   logic aneg_fault;
   wire logic [9:0] hit_raw;
   pie_word_t event_hit;
   pie_word_t gated;

   // decoded access, valid only at the accepting edge
   logic accept;
   logic wr_mask;
   logic wr_status;
   logic wr_ctrl;
   pie_word_t lane_en;
   pie_word_t wdata16;

   // request taken when waitrequest is already low
   assign accept = (i_avs_read | i_avs_write) & ~wait_r;
   assign wr_mask = accept & i_avs_write & (i_avs_address == ADDR_MASK);
   assign wr_status = accept & i_avs_write & (i_avs_address == ADDR_STATUS);
   assign wr_ctrl = accept & i_avs_write & (i_avs_address == ADDR_CTRL);
   assign lane_en = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wdata16 = i_avs_writedata[15:0];

   // gather the live line levels for change detection
   assign aneg_fault = i_ms_fault | i_pd_fault | i_no_common_hcd | i_link_timeout; // [RL10]
   assign now_lv = {aneg_fault, i_speed_100, i_full_duplex, i_page_rx, i_link_up,
                    i_mdix, i_downgrade, i_polarity_rev, i_jabber};

   // bus handshake: one wait cycle, then answer for one cycle
   always_comb begin
      bus_nxt = bus_r;
      wait_nxt = wait_r;
      rdata_nxt = rdata_r;
      unique case (bus_r)
         PIE_BUS_IDLE: begin
            wait_nxt = 1'b1;
            if (i_avs_read | i_avs_write) begin
               bus_nxt = PIE_BUS_ANSWER;
               wait_nxt = 1'b0;
               rdata_nxt = 32'h0000_0000;
               if (i_avs_read) begin
                  unique case (i_avs_address)
                     ADDR_MASK: rdata_nxt = {16'h0000, mask_r}; // [RL2]
                     ADDR_STATUS: rdata_nxt = {16'h0000, status_r};
                     default: rdata_nxt = 32'h0000_0000;
                  endcase
               end
            end
         end
         PIE_BUS_ANSWER: begin
            bus_nxt = PIE_BUS_IDLE;
            wait_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         bus_r <= PIE_BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         bus_r <= bus_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // edge history is primed one cycle after reset release, so no false event follows it
   always_comb begin
      primed_nxt = 1'b1;
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         primed_r <= 1'b0;
      end else begin
         primed_r <= primed_nxt;
      end
   end

   // one detector per event; the link level feeds a fall and a rise detector
   pie_edge_det #(.KIND(`PIE_KIND_RISE)) aneg_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[8]), .o_hit(hit_raw[9])); // [RL10]
   pie_edge_det #(.KIND(`PIE_KIND_TOGGLE)) speed_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[7]), .o_hit(hit_raw[8]));
   pie_edge_det #(.KIND(`PIE_KIND_TOGGLE)) duplex_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[6]), .o_hit(hit_raw[7]));
   pie_edge_det #(.KIND(`PIE_KIND_RISE)) page_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[5]), .o_hit(hit_raw[6]));
   pie_edge_det #(.KIND(`PIE_KIND_FALL)) link_fail_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[4]), .o_hit(hit_raw[5]));
   pie_edge_det #(.KIND(`PIE_KIND_RISE)) link_ok_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[4]), .o_hit(hit_raw[4]));
   pie_edge_det #(.KIND(`PIE_KIND_TOGGLE)) xover_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[3]), .o_hit(hit_raw[3]));
   pie_edge_det #(.KIND(`PIE_KIND_RISE)) downgrade_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[2]), .o_hit(hit_raw[2]));
   pie_edge_det #(.KIND(`PIE_KIND_TOGGLE)) polarity_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[1]), .o_hit(hit_raw[1]));
   pie_edge_det #(.KIND(`PIE_KIND_RISE)) jabber_det_u (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_primed(primed_r),
      .i_level(now_lv[0]), .o_hit(hit_raw[0]));

   // place the detector pulses at their status bit positions
   always_comb begin
      event_hit = 16'h0000;
      event_hit[`PIE_B_ANEG_ERR] = hit_raw[9]; // [RL10]
      event_hit[`PIE_B_SPEED] = hit_raw[8];
      event_hit[`PIE_B_DUPLEX] = hit_raw[7];
      event_hit[`PIE_B_PAGE] = hit_raw[6];
      event_hit[`PIE_B_LINK_FAIL] = hit_raw[5];
      event_hit[`PIE_B_LINK_OK] = hit_raw[4];
      event_hit[`PIE_B_XOVER] = hit_raw[3];
      event_hit[`PIE_B_DOWNGRADE] = hit_raw[2];
      event_hit[`PIE_B_POLARITY] = hit_raw[1];
      event_hit[`PIE_B_JABBER] = hit_raw[0];
   end

   // mask register, latched status, software reset pulse
   always_comb begin
      mask_nxt = mask_r;
      status_nxt = status_r;
      swrst_nxt = 1'b0;
      // lane merge of a mask write, reserved bits kept as storage
      if (wr_mask) begin
         mask_nxt = (mask_r & ~lane_en) | (wdata16 & lane_en); // [RL1] [RL2] [RL9]
      end
      // software reset keeps enables, clears reserved bit 8
      if (swrst_r) begin
         mask_nxt = mask_nxt & `PIE_SOFT_KEEP; // [RL3] [RL9]
      end
      // write one to clear; a new event in the same cycle wins
      if (wr_status) begin
         status_nxt = status_r & ~(wdata16 & lane_en);
      end
      status_nxt = (status_nxt | event_hit) & `PIE_EVENT_BITS;
      // software reset request, self clearing
      if (wr_ctrl & i_avs_byteenable[1]) begin
         swrst_nxt = i_avs_writedata[`PIE_B_SOFT_RESET];
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         mask_r <= `PIE_MASK_RESET; // [RL3] [RL9]
         status_r <= `PIE_STATUS_RESET;
         swrst_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         swrst_r <= swrst_nxt;
      end
   end

   // interrupt level: each latched event gated by its own enable; reserved bits never gate
   always_comb begin
      gated = 16'h0000;
      gated[`PIE_B_ANEG_ERR] = status_r[`PIE_B_ANEG_ERR] & mask_r[`PIE_B_ANEG_ERR]; // [RL4]
      gated[`PIE_B_SPEED] = status_r[`PIE_B_SPEED] & mask_r[`PIE_B_SPEED]; // [RL5]
      gated[`PIE_B_DUPLEX] = status_r[`PIE_B_DUPLEX] & mask_r[`PIE_B_DUPLEX]; // [RL5]
      gated[`PIE_B_PAGE] = status_r[`PIE_B_PAGE] & mask_r[`PIE_B_PAGE]; // [RL5]
      gated[`PIE_B_LINK_FAIL] = status_r[`PIE_B_LINK_FAIL] & mask_r[`PIE_B_LINK_FAIL]; // [RL6]
      gated[`PIE_B_LINK_OK] = status_r[`PIE_B_LINK_OK] & mask_r[`PIE_B_LINK_OK]; // [RL6]
      gated[`PIE_B_XOVER] = status_r[`PIE_B_XOVER] & mask_r[`PIE_B_XOVER]; // [RL7]
      gated[`PIE_B_DOWNGRADE] = status_r[`PIE_B_DOWNGRADE] & mask_r[`PIE_B_DOWNGRADE]; // [RL7]
      gated[`PIE_B_POLARITY] = status_r[`PIE_B_POLARITY] & mask_r[`PIE_B_POLARITY]; // [RL8]
      gated[`PIE_B_JABBER] = status_r[`PIE_B_JABBER] & mask_r[`PIE_B_JABBER]; // [RL8]
      irq_nxt = |gated; // [RL11] [RL2] [RL3] [RL9]
   end

   // interrupt output register
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // outputs straight from flip-flops
   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;
   assign o_soft_reset = swrst_r;
   assign o_irq = irq_r;

endmodule // pie_event_irq

// one level-change detector: rise, fall or toggle, quiet until primed
module pie_edge_det
   import pie_pkg::*;
#(
   parameter logic [1:0] KIND = `PIE_KIND_RISE
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_primed,
   input wire logic i_level,
   output logic o_hit
);

   logic prev_r;
   logic prev_nxt;

   // compare the level with its value one cycle earlier
   always_comb begin
      prev_nxt = i_level;
      o_hit = 1'b0;
      if (i_primed) begin
         if (KIND == `PIE_KIND_RISE) begin
            o_hit = i_level & ~prev_r;
         end else if (KIND == `PIE_KIND_FALL) begin
            o_hit = ~i_level & prev_r;
         end else begin
            o_hit = i_level ^ prev_r;
         end
      end
   end

   // level history; resets to the idle low level
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

endmodule // pie_edge_det

// [tb/pie_line_model.sv]
// line side model: live line and fault levels seen by the block
`timescale 1ns/1ps
module pie_line_model (
   input wire logic i_clock,
   input wire logic [11:0] i_lines,
   output logic [11:0] o_lines = 12'h000
);
   // levels move one clock after the bench asks, like real line status
   always @(posedge i_clock) begin
      o_lines <= i_lines;
   end
endmodule // pie_line_model

// [tb/pie_event_irq_properties.sv]
// port assertions of the event interrupt mask block
`timescale 1ns/1ps
module pie_event_irq_properties (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_soft_reset,
   input wire logic [31:0] i_avs_writedata,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);
   // read answer qualifier
   wire rda = i_avs_read && !o_avs_waitrequest;
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("bus request not answered");
   a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_no_request: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
      else $error("answer without request");
   a_upper_zero: assert property (rda |-> o_avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_unmapped_zero: assert property (rda && i_avs_address != 8'h48
      && i_avs_address != 8'h4C |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_rsvd: assert property (rda && i_avs_address == 8'h4C
      |-> (o_avs_readdata[15:0] & 16'h039C) == 16'h0000) else $error("reserved status set");
   a_data_hold: assert property (o_avs_waitrequest |-> $stable(o_avs_readdata))
      else $error("read data moved between answers");
   a_soft_pulse: assert property (o_soft_reset |=> !o_soft_reset)
      else $error("soft reset pulse too long");
   a_soft_cause: assert property ($rose(o_soft_reset) |-> $past(i_avs_write
      && !o_avs_waitrequest && i_avs_address == 8'h00 && i_avs_writedata[15]))
      else $error("soft reset without control write");
   a_irq_fall: assert property ($fell(o_irq)
      |-> $past(i_avs_write && !o_avs_waitrequest, 2))
      else $error("interrupt dropped without a write");
   c_irq: cover property ($rose(o_irq));
   c_soft: cover property ($rose(o_soft_reset));
   c_read: cover property (rda);
endmodule // pie_event_irq_properties
bind pie_event_irq pie_event_irq_properties chk_u (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_soft_reset(o_soft_reset), .i_avs_writedata(i_avs_writedata), .o_irq(o_irq));

// [tb/tb_top.sv]
// self-checking bench of the event interrupt mask block
`timescale 1ns/1ps
module tb_top;
   import pie_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdat;
   logic wrq, sres, irq;
   logic [11:0] lines = 12'h000;
   logic [11:0] lv;
   pie_word_t got;
   int fails = 0;
   int cmp_count = 0;
   int eb[13] = '{14, 13, 12, 10, 11, 6, 5, 1, 0, 15, 15, 15, 15};
   int el[13] = '{0, 1, 2, 3, 3, 4, 5, 6, 7, 8, 9, 10, 11};
   pie_line_model line_u (.i_clock(clk), .i_lines(lines), .o_lines(lv));
   pie_event_irq dut_u (.i_clock(clk), .i_resetn(rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wrq), .i_speed_100(lv[0]),
      .i_full_duplex(lv[1]), .i_page_rx(lv[2]), .i_link_up(lv[3]), .i_mdix(lv[4]),
      .i_downgrade(lv[5]), .i_polarity_rev(lv[6]), .i_jabber(lv[7]), .i_ms_fault(lv[8]),
      .i_pd_fault(lv[9]), .i_no_common_hcd(lv[10]), .i_link_timeout(lv[11]),
      .o_soft_reset(sres), .o_irq(irq));
   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(string n, pie_word_t s, pie_word_t e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // one bus cycle held until waitrequest is sampled low
   task automatic bus(logic w, logic [7:0] a, pie_word_t d, logic [3:0] b);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {16'h0000, d};
      be <= b;
      do begin
         @(posedge clk);
      end while (wrq !== 1'b0);
      got = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      bus(1'b0, 8'h48, 16'h0000, 4'hF);
      chk("mask reset", got, 16'h0000);
      chk("irq reset", irq, 16'h0000);
   endtask
   task automatic t_rw();
      bus(1'b1, 8'h48, 16'hFFFF, 4'hF);
      bus(1'b0, 8'h48, 16'h0000, 4'hF);
      chk("mask all", got, 16'hFFFF);
      bus(1'b1, 8'h48, 16'h0000, 4'h1);
      bus(1'b0, 8'h48, 16'h0000, 4'hF);
      chk("mask lane", got, 16'hFF00);
      bus(1'b1, 8'h20, 16'h1234, 4'hF);
      bus(1'b0, 8'h20, 16'h0000, 4'hF);
      chk("unmapped", got, 16'h0000);
   endtask
   task automatic t_soft();
      bus(1'b1, 8'h48, 16'hFFFF, 4'hF);
      bus(1'b1, 8'h00, 16'h8000, 4'hF);
      #1;
      chk("soft pulse", sres, 16'h0001);
      cyc(1);
      chk("soft end", sres, 16'h0000);
      cyc(2);
      bus(1'b0, 8'h48, 16'h0000, 4'hF);
      chk("mask soft", got, 16'hFEFF);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h48, 16'h0000, 4'hF);
      chk("mask hard", got, 16'h0000);
   endtask
   // each event: blocked by its own zero, latched, enabled, cleared
   task automatic t_events();
      pie_word_t m;
      for (int i = 0; i < 13; i++) begin
         m = 16'h0001 << eb[i];
         bus(1'b1, 8'h48, ~m, 4'hF);
         lines[el[i]] <= (i != 4);
         cyc(4);
         chk("irq blocked", irq, 16'h0000);
         bus(1'b0, 8'h4C, 16'h0000, 4'hF);
         chk("status", got, m);
         bus(1'b1, 8'h48, m, 4'hF);
         if (i > 8) lines[el[i]] <= 1'b0;
         cyc(2);
         chk("irq set", irq, 16'h0001);
         bus(1'b1, 8'h48, 16'h0000, 4'hF);
         cyc(2);
         chk("irq unmask", irq, 16'h0000);
         bus(1'b1, 8'h48, m, 4'hF);
         cyc(2);
         chk("irq remask", irq, 16'h0001);
         bus(1'b1, 8'h4C, m, 4'hF);
         cyc(2);
         chk("irq clear", irq, 16'h0000);
      end
   endtask
   task automatic end_sim();
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_rw();
      t_soft();
      t_events();
      end_sim();
   end
   // watchdog
   initial begin
      #50000;
      fails++;
      end_sim();
   end
endmodule // tb_top
